// ### hdl/fmfc_base_lut.sv
// Monotonic map from peak current level to base drive current command
`timescale 1ns/1ps
module fmfc_base_lut #(
    parameter logic [fmfc_pkg::LVL_W-1:0] BP [fmfc_pkg::BASE_BP_N] =
        '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hb0, 8'hd0}
) (
    // Level in, command out
    input  wire logic [fmfc_pkg::LVL_W-1:0]  level,
    output      logic [fmfc_pkg::BASE_W-1:0] cmd_ma
);
    import fmfc_pkg::*;

    function automatic logic [BASE_W-1:0] steps_of(input logic [LVL_W-1:0] lv);
        logic [BASE_W-1:0] n;
        n = '0;
        for (int i = 0; i < BASE_BP_N; i++)
            if (lv >= BP[i])
                n = n + 5'h01;
        return n;
    endfunction

    wire logic [BASE_W-1:0] n_steps = steps_of(level);

    // 10 mA plus 3 mA per breakpoint passed
    assign cmd_ma = BASE_MIN_MA + BASE_W'(n_steps * BASE_STEP_MA);
endmodule

// ### hdl/fmfc_ctrl.sv
// Switching sequencer of the flyback controller: modes, valley turn-on, protection
//
// Notes on behaviour
// - Heavy load: PWM, fixed period, on-time varies
// - Lighter load: PFM, fixed on-time, longer off
// - Lightest load: deep PFM, very long off
// - Every turn-on except the first one from idle waits for a resonant valley
// - Off-time extends until auxiliary falling edge
// - Reset wait reaching 75 us is fault
// - Overvoltage at sampling point is fault
// - On-time capped 15 us; reaching it faults
// - Below lockout, switching stops immediately
// - After fault stay biased, retry after lockout
// - Above 1.1 V sense, cut drive this cycle
// - Next cycle issues a fresh pulse again
// - Several consecutive overcurrent cycles cause shutdown
// - Shorted sense resistor after startup is fault
// - Base current command spans 10 to 31 mA
// - Start threshold enables logic, soft start ramps
// - No auxiliary voltage means winding fault, shutdown
`timescale 1ns/1ps
module fmfc_ctrl #(
    parameter int RESET_MAX_CYC  = fmfc_pkg::RESET_MAX_CYC,
    parameter int DEEP_PULSE_FREQUENCY_MODE_OFF_CYC   = fmfc_pkg::DEEP_PULSE_FREQUENCY_MODE_OFF_DEF,
    parameter int PWM_PERIOD_CYC = fmfc_pkg::PWM_PERIOD_DEF,
    parameter int OC_LIMIT       = fmfc_pkg::OC_LIMIT_DEF
) (
    // Clock, reset, freeze
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          ce,
    // Supply comparators
    input  wire logic                          supply_ok,
    input  wire logic                          supply_start,
    // Regulation and sense comparators
    input  wire logic [fmfc_pkg::LVL_W-1:0]    load_level,
    input  wire logic [fmfc_pkg::LVL_W-1:0]    peak_current_level,
    input  wire logic                          aux_fall,
    input  wire logic                          aux_present,
    input  wire logic                          aux_ovp,
    input  wire logic                          valley,
    input  wire logic                          isense_oc,
    input  wire logic                          sense_short,
    // Driver commands
    output      logic                          drive_on,
    output      logic [fmfc_pkg::BASE_W-1:0]   base_current_ma,
    // Status
    output      logic                          enable,
    output      logic                          soft_start,
    output      fmfc_pkg::fmfc_mode_type       mode,
    output      logic                          overcurrent,
    output      logic                          shutdown,
    output      fmfc_pkg::fmfc_cause_type      fault_cause
);
    import fmfc_pkg::*;

    localparam logic [CNT_W-1:0] RESET_MAX  = CNT_W'(RESET_MAX_CYC);
    localparam logic [CNT_W-1:0] TON_MAX    = CNT_W'(TON_MAX_CYC);
    localparam logic [CNT_W-1:0] DEEP_PULSE_FREQUENCY_MODE_OFF   = CNT_W'(DEEP_PULSE_FREQUENCY_MODE_OFF_CYC);
    localparam logic [CNT_W-1:0] PWM_PERIOD = CNT_W'(PWM_PERIOD_CYC);

    // Count reaches its limit at the end of this cycle
    function automatic logic reached(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] lim
    );
        return (cnt + 16'h0001) >= lim;
    endfunction

    fmfc_evt_if evt ();

    fmfc_phase_type         phase_reg;
    fmfc_phase_type         phase_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       ss_reg;
    logic                   oc_cycle_reg;
    logic                   enable_reg;
    logic                   drive_reg;
    logic                   ss_active_reg;
    fmfc_mode_type          mode_reg;
    logic [BASE_W-1:0]      base_reg;
    logic                   oc_flag_reg;
    logic                   shut_reg;
    fmfc_cause_type         cause_reg;
    logic [BASE_W-1:0]      lut_ma;

    fmfc_fault #(
        .OC_LIMIT (OC_LIMIT)
    ) u_fault (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .evt    (evt)
    );

    fmfc_base_lut u_lut (
        .level  (peak_current_level),
        .cmd_ma (lut_ma)
    );

    // Load decides the modulation mode
    wire logic is_pwm  = load_level >= PWM_LOAD_THR;
    wire logic is_deep_pulse_frequency_mode = load_level < DEEP_PULSE_FREQUENCY_MODE_LOAD_THR;
    wire fmfc_mode_type mode_sel = is_pwm ? MODE_PWM : (is_deep_pulse_frequency_mode ? MODE_DEEP_PULSE_FREQUENCY_MODE : MODE_PFM);

    wire logic [CNT_W-1:0] ton_pwm = CNT_W'(load_level) * TON_STEP;
    // fixed on-time in PFM and deep PFM
    wire logic [CNT_W-1:0] ton_dem = is_pwm ? ton_pwm : PFM_TON_CYC;
    wire logic [CNT_W-1:0] ton_tgt = (ton_dem < ss_reg) ? ton_dem : ss_reg;

    // PWM off-time keeps the period near constant; PFM off-time grows as load falls
    wire logic [CNT_W-1:0] off_pwm = (PWM_PERIOD > ton_tgt) ? PWM_PERIOD - ton_tgt : 16'h0001;
    wire logic [CNT_W-1:0] off_pfm = (PWM_PERIOD - PFM_TON_CYC)
                                   + CNT_W'(PWM_LOAD_THR - load_level) * OFF_STEP;
    // very long off-time at lightest load
    wire logic [CNT_W-1:0] off_tgt = is_pwm ? off_pwm : (is_deep_pulse_frequency_mode ? DEEP_PULSE_FREQUENCY_MODE_OFF : off_pfm);

    wire logic [CNT_W-1:0] cnt_inc = cnt_reg + 16'h0001;
    wire logic run      = enable_reg & ~evt.shut;
    wire logic in_on    = phase_reg == PH_ON;
    wire logic in_rst   = phase_reg == PH_RESET;
    wire logic in_wait  = phase_reg == PH_WAIT;
    wire logic in_valley = phase_reg == PH_VALLEY;
    wire logic rst_first = in_rst && cnt_reg == 16'h0000;

    // current limit ends the pulse now
    wire logic oc_cut   = in_on & isense_oc;
    wire logic ton_cap  = in_on & ~isense_oc & reached(cnt_reg, TON_MAX);
    wire logic ton_done = in_on & reached(cnt_reg, ton_tgt);
    wire logic rst_done = in_rst & aux_fall;
    wire logic rst_to   = in_rst & ~aux_fall & reached(cnt_reg, RESET_MAX);
    wire logic wait_done = in_wait & reached(cnt_reg, off_tgt);
    wire logic turn_on  = in_valley & valley;

    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_IDLE:
                if (run)
                    phase_next = PH_ON;

            PH_ON:
                if (oc_cut || ton_done)
                    phase_next = PH_RESET;

            PH_RESET:
                if (rst_done)
                    phase_next = PH_WAIT;

            PH_WAIT:
                if (wait_done)
                    phase_next = PH_VALLEY;

            PH_VALLEY:
                if (turn_on)
                    phase_next = PH_ON;

            default:
                phase_next = PH_IDLE;
        endcase
        // lockout or latched fault stops switching
        if (!run || !supply_ok)
            phase_next = PH_IDLE;
    end

    // Events to the supervisor
    assign evt.clear       = ~supply_ok;
    // every valley turn-on is a fresh pulse
    assign evt.cycle_end   = run & turn_on;
    assign evt.cycle_oc    = oc_cycle_reg;
    assign evt.ev_reset_to = run & rst_to;
    assign evt.ev_ovp      = run & rst_done & aux_ovp;
    assign evt.ev_ton_max  = run & ton_cap;
    assign evt.ev_short    = run & sense_short;
    // no auxiliary voltage after a pulse
    assign evt.ev_aux      = run & rst_first & ~aux_present;

    // Phase and its cycle count
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= 16'h0000;
        end
        else if (ce)
        begin
            phase_reg <= phase_next;
            cnt_reg   <= (phase_next != phase_reg) ? 16'h0000 : cnt_inc;
        end
    end

    // remember overcurrent until the cycle ends
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            oc_cycle_reg <= 1'b0;
        else if (ce)
        begin
            if (phase_next == PH_IDLE || turn_on)
                oc_cycle_reg <= 1'b0;
            else if (oc_cut)
                oc_cycle_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            enable_reg <= 1'b0;
        else if (ce)
        begin
            if (!supply_ok)
                enable_reg <= 1'b0;
            else if (supply_start)
                enable_reg <= 1'b1;
        end
    end

    // soft start widens pulses up to the cap
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ss_reg        <= SS_INIT_CYC;
            ss_active_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!supply_ok)
            begin
                ss_reg        <= SS_INIT_CYC;
                ss_active_reg <= 1'b0;
            end
            else if (supply_start && !enable_reg)
                ss_active_reg <= 1'b1;
            else if (turn_on && ss_active_reg)
            begin
                if (ss_reg >= TON_MAX - SS_STEP_CYC)
                begin
                    ss_reg        <= TON_MAX;
                    ss_active_reg <= 1'b0;
                end
                else
                    ss_reg <= ss_reg + SS_STEP_CYC;
            end
        end
    end

    // drive high only through the on phase
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            drive_reg   <= 1'b0;
            oc_flag_reg <= 1'b0;
        end
        else if (ce)
        begin
            drive_reg   <= phase_next == PH_ON;
            oc_flag_reg <= oc_cut;
        end
    end

    // Registered status and base command
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_reg  <= MODE_IDLE;
            base_reg  <= BASE_MIN_MA;
            shut_reg  <= 1'b0;
            cause_reg <= CAUSE_NONE;
        end
        else if (ce)
        begin
            mode_reg  <= run ? mode_sel : MODE_IDLE;
            base_reg  <= lut_ma;
            shut_reg  <= evt.shut;
            cause_reg <= evt.cause;
        end
    end

    assign drive_on        = drive_reg;
    assign base_current_ma = base_reg;
    assign enable          = enable_reg;
    assign soft_start      = ss_active_reg;
    assign mode            = mode_reg;
    assign overcurrent     = oc_flag_reg;
    assign shutdown        = shut_reg;
    assign fault_cause     = cause_reg;
endmodule

// ### hdl/fmfc_fault.sv
// Fault supervisor: consecutive overcurrent count and latched shutdown
`timescale 1ns/1ps
module fmfc_fault #(
    parameter int OC_LIMIT = fmfc_pkg::OC_LIMIT_DEF
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Events
    fmfc_evt_if.mon   evt
);
    import fmfc_pkg::*;

    logic [7:0]     oc_cnt_reg;
    logic           shut_reg;
    fmfc_cause_type cause_reg;

    wire logic [7:0] oc_cnt_inc = oc_cnt_reg + 8'h01;
    wire logic oc_trip = evt.cycle_end & evt.cycle_oc & (int'(oc_cnt_inc) >= OC_LIMIT);
    wire logic any_ev  = evt.ev_reset_to | evt.ev_ovp | evt.ev_ton_max | evt.ev_short
                       | evt.ev_aux | oc_trip;
    wire fmfc_cause_type cause_next =
        evt.ev_short    ? CAUSE_SHORT    :
        evt.ev_ovp      ? CAUSE_OVP      :
        evt.ev_ton_max  ? CAUSE_TON_MAX  :
        evt.ev_reset_to ? CAUSE_RESET_TO :
        evt.ev_aux      ? CAUSE_AUX      : CAUSE_OC;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oc_cnt_reg <= 8'h00;
            shut_reg   <= 1'b0;
            cause_reg  <= CAUSE_NONE;
        end
        else if (ce)
        begin
            // lockout clears the latch for a new attempt
            if (evt.clear)
            begin
                oc_cnt_reg <= 8'h00;
                shut_reg   <= 1'b0;
                cause_reg  <= CAUSE_NONE;
            end
            else
            begin
                if (evt.cycle_end)
                    oc_cnt_reg <= evt.cycle_oc ? oc_cnt_inc : 8'h00;
                if (any_ev && !shut_reg)
                begin
                    shut_reg  <= 1'b1;
                    cause_reg <= cause_next;
                end
            end
        end
    end

    assign evt.shut  = shut_reg;
    assign evt.cause = cause_reg;
endmodule

// ### pkg/fmfc_evt_if.sv
// Event carrier between the switching sequencer and the fault supervisor
`timescale 1ns/1ps
interface fmfc_evt_if;
    import fmfc_pkg::*;
    logic           clear;
    logic           cycle_end;
    logic           cycle_oc;
    logic           ev_reset_to;
    logic           ev_ovp;
    logic           ev_ton_max;
    logic           ev_short;
    logic           ev_aux;
    logic           shut;
    fmfc_cause_type cause;
    modport ctrl (output clear, cycle_end, cycle_oc, ev_reset_to, ev_ovp, ev_ton_max,
                  ev_short, ev_aux, input shut, cause);
    modport mon  (input clear, cycle_end, cycle_oc, ev_reset_to, ev_ovp, ev_ton_max,
                  ev_short, ev_aux, output shut, cause);
endinterface

// ### pkg/fmfc_pkg.sv
// Constants, timing counts and enumerations of the flyback mode and fault controller
package fmfc_pkg;
    localparam int CLK_MHZ      = 250;
    localparam int CNT_W        = 16;
    localparam int LVL_W        = 8;
    localparam int BASE_W       = 5;
    // Longest transformer reset wait and on-time cap, in microseconds
    localparam int RESET_MAX_US = 75;
    localparam int TON_MAX_US   = 15;
    localparam int RESET_MAX_CYC = RESET_MAX_US * CLK_MHZ;
    localparam int TON_MAX_CYC   = TON_MAX_US * CLK_MHZ;
    // Mode thresholds on the load level
    localparam logic [LVL_W-1:0] PWM_LOAD_THR  = 8'h20;
    localparam logic [LVL_W-1:0] DEEP_PULSE_FREQUENCY_MODE_LOAD_THR = 8'h08;
    // Cycle shaping defaults
    localparam logic [CNT_W-1:0] TON_STEP      = 16'h0010;
    localparam logic [CNT_W-1:0] PFM_TON_CYC   = 16'h0200;
    localparam logic [CNT_W-1:0] OFF_STEP      = 16'h0200;
    localparam int               PWM_PERIOD_DEF = 8000;
    localparam int               DEEP_PULSE_FREQUENCY_MODE_OFF_DEF   = 60000;
    localparam logic [CNT_W-1:0] SS_INIT_CYC   = 16'h0040;
    localparam logic [CNT_W-1:0] SS_STEP_CYC   = 16'h0020;
    localparam int               OC_LIMIT_DEF  = 4;
    // Base drive command in mA
    localparam logic [BASE_W-1:0] BASE_MIN_MA  = 5'h0a;
    localparam logic [BASE_W-1:0] BASE_STEP_MA = 5'h03;
    localparam int                BASE_BP_N    = 7;

    typedef enum logic [1:0] {MODE_IDLE, MODE_PWM, MODE_PFM, MODE_DEEP_PULSE_FREQUENCY_MODE} fmfc_mode_type;
    typedef enum logic [2:0] {PH_IDLE, PH_ON, PH_RESET, PH_WAIT, PH_VALLEY} fmfc_phase_type;
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_RESET_TO, CAUSE_OVP, CAUSE_TON_MAX,
        CAUSE_OC, CAUSE_SHORT, CAUSE_AUX
    } fmfc_cause_type;
endpackage

// ### tb/fmfc_chk.sv
// Property checker on the controller top ports
`timescale 1ns/1ps
module fmfc_chk (
    // Clock and reset
    input wire logic                           clk,
    input wire logic                           resetn,
    input wire logic                           ce,
    // Inputs watched
    input wire logic                           supply_ok,
    input wire logic                           supply_start,
    input wire logic                           valley,
    input wire logic                           isense_oc,
    // Outputs watched
    input wire logic                           drive_on,
    input wire logic [fmfc_pkg::BASE_W-1:0]    base_current_ma,
    input wire logic                           enable,
    input wire logic                           soft_start,
    input wire fmfc_pkg::fmfc_mode_type        mode,
    input wire logic                           overcurrent,
    input wire logic                           shutdown,
    input wire fmfc_pkg::fmfc_cause_type       fault_cause
);
    import fmfc_pkg::*;
    logic ran_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Set once a pulse has been seen since enable
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            ran_reg <= 1'b0;
        else
            ran_reg <= enable && (ran_reg || drive_on);
    property p_enable;
        supply_ok && supply_start && !enable && !shutdown && ce |=> enable && soft_start;
    endproperty
    a_enable: assert property (p_enable) else $error("enable missed");
    property p_first;
        $rose(enable) |-> ##[1:3] drive_on;
    endproperty
    a_first: assert property (p_first) else $error("no first pulse");
    property p_uvlo;
        !supply_ok && ce |=> !enable ##1 !drive_on;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("drive under lockout");
    property p_cut;
        drive_on && isense_oc && ce |-> ##[1:2] !drive_on;
    endproperty
    a_cut: assert property (p_cut) else $error("drive not cut");
    property p_flag;
        drive_on && isense_oc && ce && supply_ok |-> ##[1:3] overcurrent;
    endproperty
    a_flag: assert property (p_flag) else $error("overcurrent not flagged");
    property p_pulse;
        overcurrent |=> !overcurrent;
    endproperty
    a_pulse: assert property (p_pulse) else $error("overcurrent too long");
    property p_valley;
        $rose(drive_on) && ran_reg |-> $past(valley) || $past(valley, 2) || $past(valley, 3);
    endproperty
    a_valley: assert property (p_valley) else $error("turn-on off valley");
    property p_hold;
        shutdown && supply_ok && ce |=> shutdown && $stable(fault_cause);
    endproperty
    a_hold: assert property (p_hold) else $error("fault not held");
    property p_quiet;
        shutdown |=> !drive_on;
    endproperty
    a_quiet: assert property (p_quiet) else $error("drive during fault");
    property p_cause;
        $rose(shutdown) |-> fault_cause != CAUSE_NONE;
    endproperty
    a_cause: assert property (p_cause) else $error("fault without cause");
    property p_base;
        base_current_ma >= BASE_MIN_MA;
    endproperty
    a_base: assert property (p_base) else $error("base current low");
    c_shut: cover property ($rose(shutdown));
    c_oc: cover property (overcurrent);
    c_deep: cover property ($rose(drive_on) && mode == MODE_DEEP_PULSE_FREQUENCY_MODE);
endmodule

bind fmfc_ctrl fmfc_chk fmfc_chk_i (
    .clk(clk), .resetn(resetn), .ce(ce), .supply_ok(supply_ok),
    .supply_start(supply_start), .valley(valley), .isense_oc(isense_oc),
    .drive_on(drive_on), .base_current_ma(base_current_ma), .enable(enable),
    .soft_start(soft_start), .mode(mode), .overcurrent(overcurrent),
    .shutdown(shutdown), .fault_cause(fault_cause)
);

// ### tb/fmfc_sense_model.sv
// Behavioural switch and sense comparators around the controller
`timescale 1ns/1ps
module fmfc_sense_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Drive and fault knobs
    input  wire logic drive_on,
    input  wire logic oc_arm,
    input  wire logic ovp_arm,
    input  wire logic no_fall,
    input  wire logic no_aux,
    // Comparators
    output wire logic aux_fall,
    output wire logic aux_ovp,
    output wire logic aux_present,
    output wire logic valley,
    output wire logic isense_oc
);
    logic [7:0] on_reg;
    logic [7:0] off_reg;
    logic [3:0] ring_reg;
    // Demagnetising ends 12 cycles after turn-off
    assign aux_fall    = !drive_on && off_reg == 8'h0c && !no_fall;
    assign aux_ovp     = aux_fall && ovp_arm;
    assign aux_present = !no_aux;
    // Ringing valleys every 16 cycles afterwards
    assign valley      = !drive_on && off_reg > 8'h0c && ring_reg == 4'h0;
    assign isense_oc   = drive_on && oc_arm && on_reg == 8'h14;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            on_reg   <= 8'h00;
            off_reg  <= 8'h00;
            ring_reg <= 4'h0;
        end
        else
        begin
            ring_reg <= ring_reg + 4'h1;
            on_reg   <= drive_on ? on_reg + {7'h00, on_reg != 8'hff} : 8'h00;
            off_reg  <= drive_on ? 8'h00 : off_reg + {7'h00, off_reg != 8'hff};
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the flyback mode and fault controller
`timescale 1ns/1ps
module tb_top;
    import fmfc_pkg::*;
    localparam int PER = 4100;
    localparam logic [7:0] LOADS [3] = '{8'h28, 8'h1f, 8'h04};
    localparam fmfc_mode_type MODES [3] = '{MODE_PWM, MODE_PFM, MODE_DEEP_PULSE_FREQUENCY_MODE};
    localparam int LO [3] = '{4112, 4176, 312};
    localparam fmfc_cause_type CAUSES [4] = '{CAUSE_RESET_TO, CAUSE_OVP, CAUSE_SHORT, CAUSE_AUX};
    logic           clk, resetn, ce, supply_ok, supply_start, sense_short;
    logic           oc_arm, ovp_arm, no_fall, no_aux;
    logic [7:0]     load_level, peak_current_level;
    wire logic      aux_fall, aux_ovp, aux_present, valley, isense_oc;
    wire logic      drive_on, enable, soft_start, overcurrent, shutdown;
    wire logic [4:0] base_current_ma;
    fmfc_mode_type  mode;
    fmfc_cause_type fault_cause;
    int             fail_count;
    int             check_count;

    fmfc_ctrl #(.RESET_MAX_CYC(200), .DEEP_PULSE_FREQUENCY_MODE_OFF_CYC(300), .PWM_PERIOD_CYC(PER), .OC_LIMIT(3))
    fmfc_ctrl_i (.clk(clk), .resetn(resetn), .ce(ce), .supply_ok(supply_ok),
        .supply_start(supply_start), .load_level(load_level),
        .peak_current_level(peak_current_level), .aux_fall(aux_fall),
        .aux_present(aux_present), .aux_ovp(aux_ovp), .valley(valley),
        .isense_oc(isense_oc), .sense_short(sense_short), .drive_on(drive_on),
        .base_current_ma(base_current_ma), .enable(enable), .soft_start(soft_start),
        .mode(mode), .overcurrent(overcurrent), .shutdown(shutdown),
        .fault_cause(fault_cause));
    fmfc_sense_model fmfc_sense_model_i (.clk(clk), .resetn(resetn), .drive_on(drive_on),
        .oc_arm(oc_arm), .ovp_arm(ovp_arm), .no_fall(no_fall), .no_aux(no_aux),
        .aux_fall(aux_fall), .aux_ovp(aux_ovp), .aux_present(aux_present),
        .valley(valley), .isense_oc(isense_oc));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [7:0] b(input logic c);
        return {7'h00, c};
    endfunction

    function automatic logic sel(input int k);
        return k == 0 ? drive_on : k == 1 ? overcurrent : shutdown;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_for(input int k, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sel(k) !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n == lim)
            check(8'h01, 8'h00);
    endtask

    task automatic restart;
        @(posedge clk);
        supply_ok <= 1'b0;
        repeat (2) @(posedge clk);
        supply_ok <= 1'b1;
        @(negedge clk);
    endtask

    task automatic t_start;
        int t0;
        @(posedge clk);
        supply_ok <= 1'b1;
        repeat (3) @(negedge clk);
        check({6'h00, enable, drive_on}, 8'h00);
        @(posedge clk);
        supply_start <= 1'b1;
        repeat (2) @(negedge clk);
        check({6'h00, enable, soft_start}, 8'h03);
        wait_for(0, 1'b1, 8);
        t0 = $time;
        wait_for(0, 1'b0, 400);
        check(b(($time - t0) / 4 inside {[63:65]}), 8'h01);
        wait_for(0, 1'b1, PER + 100);
        @(posedge clk);
        supply_ok <= 1'b0;
        repeat (3) @(negedge clk);
        check({6'h00, enable, drive_on}, 8'h00);
        @(posedge clk);
        supply_ok <= 1'b1;
        $display("start test done");
    endtask

    task automatic t_modes;
        int t0;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            load_level <= LOADS[i];
            wait_for(0, 1'b0, 9000);
            wait_for(0, 1'b1, 9000);
            check({6'h00, mode}, {6'h00, MODES[i]});
            t0 = $time;
            wait_for(0, 1'b0, 9000);
            wait_for(0, 1'b1, 9000);
            check(b(($time - t0) / 4 inside {[LO[i]:LO[i] + 600]}), 8'h01);
        end
        $display("mode test done");
    endtask

    task automatic t_base;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            peak_current_level <= 8'(i * 32);
            repeat (3) @(negedge clk);
            check({3'h0, base_current_ma}, 8'(10 + 3 * i));
        end
        @(posedge clk);
        ce <= 1'b0;
        peak_current_level <= 8'h00;
        repeat (3) @(negedge clk);
        check({3'h0, base_current_ma}, 8'h1f);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(negedge clk);
        check({3'h0, base_current_ma}, 8'h0a);
        $display("base test done");
    endtask

    task automatic oc_hit;
        wait_for(1, 1'b1, 9000);
        wait_for(1, 1'b0, 4);
    endtask

    task automatic t_oc;
        int t0;
        @(posedge clk);
        load_level <= 8'h28;
        oc_arm <= 1'b1;
        repeat (2) oc_hit;
        @(posedge clk);
        oc_arm <= 1'b0;
        wait_for(0, 1'b1, 9000);
        t0 = $time;
        wait_for(0, 1'b0, 9000);
        check(b(($time - t0) / 4 > 21), 8'h01);
        @(posedge clk);
        oc_arm <= 1'b1;
        repeat (2) oc_hit;
        check(b(shutdown), 8'h00);
        oc_hit;
        wait_for(2, 1'b1, 9000);
        check({5'h00, fault_cause}, {5'h00, CAUSE_OC});
        @(posedge clk);
        oc_arm <= 1'b0;
        restart;
        check(b(shutdown), 8'h00);
        wait_for(0, 1'b1, 20);
        $display("overcurrent test done");
    endtask

    task automatic t_faults;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            no_fall <= k == 0;
            ovp_arm <= k == 1;
            sense_short <= k == 2;
            no_aux <= k == 3;
            repeat (2)
            begin
                restart;
                wait_for(2, 1'b1, 2000);
                check({5'h00, fault_cause}, {5'h00, CAUSES[k]});
                repeat (20) @(negedge clk);
                check({6'h00, shutdown, drive_on}, 8'h02);
            end
            @(posedge clk);
            {no_fall, ovp_arm, sense_short, no_aux} <= 4'h0;
            restart;
            wait_for(0, 1'b1, 20);
            check(b(shutdown), 8'h00);
        end
        $display("fault test done");
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        fail_count++;
        conclude;
    end

    initial
    begin
        {resetn, supply_ok, sense_short, oc_arm, ovp_arm, no_fall, no_aux} = 7'h00;
        {ce, supply_start} = 2'h2;
        load_level = 8'h28;
        peak_current_level = 8'h00;
        fail_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_start;
        t_modes;
        t_base;
        t_oc;
        t_faults;
        conclude;
    end
endmodule
